// File: core/dcap_cfg.svh
`ifndef DCAP_CFG_SVH
`define DCAP_CFG_SVH

// Configuration space map
`define DCAP_ADDR_W 12
`define DCAP_OFFSET 12'h0c4
`define DCTL_OFFSET 12'h0c8

// Capability word fields
`define DCAP_MPS_MSB 2
`define DCAP_MPS_LSB 0
`define DCAP_PHANTOM_MSB 4
`define DCAP_PHANTOM_LSB 3
`define DCAP_ETAG_BIT 5
`define DCAP_L0S_MSB 8
`define DCAP_L0S_LSB 6
`define DCAP_L1_MSB 11
`define DCAP_L1_LSB 9
`define DCAP_RSV0_MSB 14
`define DCAP_RSV0_LSB 12
`define DCAP_RBE_BIT 15
`define DCAP_RSV1_MSB 17
`define DCAP_RSV1_LSB 16
`define DCAP_SPLV_MSB 25
`define DCAP_SPLV_LSB 18
`define DCAP_SPLS_MSB 27
`define DCAP_SPLS_LSB 26
`define DCAP_RSV2_MSB 31
`define DCAP_RSV2_LSB 28

// Device control payload field
`define DCTL_MPS_MSB 7
`define DCTL_MPS_LSB 5
`define DCTL_MPS_BE 0

// Payload codes
`define DCAP_MPS_128 3'h0
`define DCAP_MPS_256 3'h1
`define DCAP_MPS_512 3'h2

// Fixed and reset values
`define DCAP_PHANTOM_VAL 2'h0
`define DCAP_ETAG_VAL 1'h0
`define DCAP_L0S_RST 3'h0
`define DCAP_L1_RST 3'h0
`define DCAP_RSV0_VAL 3'h0
`define DCAP_RSV1_VAL 2'h0
`define DCAP_RSV2_VAL 4'h0
`define DCAP_RBE_RST 1'h1
`define DCAP_SPLV_RST 8'h00
`define DCAP_SPLS_RST 2'h0
`define DCTL_MPS_RST 3'h0
`define DCAP_RDATA_ZERO 32'h0000_0000

// Strap settle time after reset release, in cycles
`define DCAP_SETTLE_CYCLES 2'h3
`define DCAP_SETTLE_ZERO 2'h0
`define DCAP_SETTLE_STEP 2'h1

`endif

// File: core/dcap_pkg.sv
package dcap_pkg;

  typedef enum logic [1:0] {
    ST_SETTLE = 2'h0,
    ST_WAIT_AGREE = 2'h1,
    ST_DONE = 2'h3
  } strap_state_type;

  typedef enum logic [1:0] {
    OVR_PAYLOAD = 2'h0,
    OVR_ROLE_ERR = 2'h1
  } ovr_sel_type;

endpackage : dcap_pkg

// File: core/strap_sync.sv
`timescale 1ns/100ps
module strap_sync #(
  parameter int WIDTH = 1
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_level,
  output logic o_stable
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  // Stage one feeds stage two only
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else if (i_ce) begin
      stage1 <= i_async;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  assign o_level = stage3;
  assign o_stable = (stage2 == stage3);

endmodule : strap_sync

// File: core/switch_port_device_capabilities.sv
`timescale 1ns/100ps
`include "dcap_cfg.svh"
module switch_port_device_capabilities
  import dcap_pkg::*;
#(
  parameter bit UPSTREAM_PORT = 1'b1
) (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_core_ce,
  input wire logic i_payload_limit_strap,
  input wire logic i_cfg_rd,
  input wire logic i_cfg_wr,
  input wire logic [`DCAP_ADDR_W-1:0] i_cfg_addr,
  input wire logic [3:0] i_cfg_be,
  input wire logic [31:0] i_cfg_wdata,
  output logic o_cfg_ack,
  output logic [31:0] o_cfg_rdata,
  input wire logic i_ovr_wr,
  input wire ovr_sel_type i_ovr_sel,
  input wire logic [2:0] i_ovr_data,
  output logic o_ovr_reject,
  input wire logic i_spl_msg_valid,
  input wire logic [7:0] i_spl_value,
  input wire logic [1:0] i_spl_scale,
  output logic [2:0] o_max_payload_code,
  output logic [2:0] o_devctl_payload,
  output logic o_strap_loaded
);

  function automatic logic payload_code_ok(input logic [2:0] code);
    payload_code_ok = (code <= `DCAP_MPS_512);
  endfunction : payload_code_ok

  function automatic logic [2:0] clamp_payload(input logic [2:0] req,
                                               input logic [2:0] cap);
    clamp_payload = (req > cap) ? cap : req;
  endfunction : clamp_payload

  // Synchronised strap
  logic strap_level;
  logic strap_stable;

  strap_sync #(
    .WIDTH(1)
  ) u_strap_sync (
    .i_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .i_ce(i_core_ce),
    .i_async(i_payload_limit_strap),
    .o_level(strap_level),
    .o_stable(strap_stable)
  );

  // State
  strap_state_type load_state;
  strap_state_type next_load_state;
  logic [1:0] settle_cnt;
  logic [1:0] next_settle_cnt;
  logic [2:0] mps_code;
  logic [2:0] next_mps_code;
  logic role_err;
  logic next_role_err;
  logic [7:0] spl_value;
  logic [7:0] next_spl_value;
  logic [1:0] spl_scale;
  logic [1:0] next_spl_scale;
  logic [2:0] devctl_mps;
  logic [2:0] next_devctl_mps;
  logic [31:0] next_rdata;
  logic next_ack;
  logic next_reject;
  logic next_strap_loaded;

  // Decode
  wire settle_done = (settle_cnt == `DCAP_SETTLE_CYCLES);
  wire strap_take = (load_state == ST_WAIT_AGREE) && strap_stable;
  wire [2:0] strap_code = strap_level ? `DCAP_MPS_512 : `DCAP_MPS_256;
  wire ovr_payload = i_ovr_wr && (i_ovr_sel == OVR_PAYLOAD);
  wire ovr_role = i_ovr_wr && (i_ovr_sel == OVR_ROLE_ERR);
  wire ovr_payload_ok = ovr_payload && payload_code_ok(i_ovr_data);
  wire ovr_payload_bad = ovr_payload && !payload_code_ok(i_ovr_data);
  wire hit_cap = (i_cfg_addr == `DCAP_OFFSET);
  wire hit_dctl = (i_cfg_addr == `DCTL_OFFSET);
  wire dctl_wr = i_cfg_wr && hit_dctl && i_cfg_be[`DCTL_MPS_BE];
  wire [2:0] dctl_req = i_cfg_wdata[`DCTL_MPS_MSB:`DCTL_MPS_LSB];
  wire spl_take = UPSTREAM_PORT && i_spl_msg_valid;

  // Capability word
  wire [31:0] cap_word;
  assign cap_word[`DCAP_MPS_MSB:`DCAP_MPS_LSB] = mps_code;
  assign cap_word[`DCAP_PHANTOM_MSB:`DCAP_PHANTOM_LSB] = `DCAP_PHANTOM_VAL;
  assign cap_word[`DCAP_ETAG_BIT] = `DCAP_ETAG_VAL;
  assign cap_word[`DCAP_L0S_MSB:`DCAP_L0S_LSB] = `DCAP_L0S_RST;
  assign cap_word[`DCAP_L1_MSB:`DCAP_L1_LSB] = `DCAP_L1_RST;
  assign cap_word[`DCAP_RSV0_MSB:`DCAP_RSV0_LSB] = `DCAP_RSV0_VAL;
  assign cap_word[`DCAP_RBE_BIT] = role_err;
  assign cap_word[`DCAP_RSV1_MSB:`DCAP_RSV1_LSB] = `DCAP_RSV1_VAL;
  assign cap_word[`DCAP_SPLV_MSB:`DCAP_SPLV_LSB] = spl_value;
  assign cap_word[`DCAP_SPLS_MSB:`DCAP_SPLS_LSB] = spl_scale;
  assign cap_word[`DCAP_RSV2_MSB:`DCAP_RSV2_LSB] = `DCAP_RSV2_VAL;

  // Device control view: only the payload field is kept here
  wire [31:0] dctl_word;
  assign dctl_word[31:`DCTL_MPS_MSB+1] = '0;
  assign dctl_word[`DCTL_MPS_MSB:`DCTL_MPS_LSB] = devctl_mps;
  assign dctl_word[`DCTL_MPS_LSB-1:0] = '0;

  // Strap capture: the pin is only trusted once the chain has filled
  always_comb begin
    next_load_state = load_state;
    next_settle_cnt = settle_cnt;
    unique case (load_state)
      ST_SETTLE: begin
        if (settle_done) begin
          next_load_state = ST_WAIT_AGREE;
        end else begin
          next_settle_cnt = settle_cnt + `DCAP_SETTLE_STEP;
        end
      end
      ST_WAIT_AGREE: begin
        if (strap_stable) begin
          next_load_state = ST_DONE;
        end
      end
      ST_DONE: begin
        next_load_state = ST_DONE;
      end
      default: begin
        next_load_state = ST_SETTLE;
        next_settle_cnt = `DCAP_SETTLE_ZERO;
      end
    endcase
    // A replaced default must not be clobbered by a late strap
    if (ovr_payload_ok) begin
      next_load_state = ST_DONE;
    end
  end

  // Payload capability: override wins over the strap
  always_comb begin
    next_mps_code = mps_code;
    if (ovr_payload_ok) begin
      next_mps_code = i_ovr_data;
    end else if (strap_take) begin
      next_mps_code = strap_code;
    end
  end

  assign next_role_err = ovr_role ? i_ovr_data[0] : role_err;
  assign next_reject = ovr_payload_bad;
  assign next_strap_loaded = (next_load_state == ST_DONE);

  // Slot power limit: downstream ports hold their reset value
  assign next_spl_value = spl_take ? i_spl_value : spl_value;
  assign next_spl_scale = spl_take ? i_spl_scale : spl_scale;

  // Control payload follows the capability if it later shrinks
  always_comb begin
    next_devctl_mps = clamp_payload(devctl_mps, next_mps_code);
    if (dctl_wr) begin
      next_devctl_mps = clamp_payload(dctl_req, next_mps_code);
    end
  end

  // Read mux; capability writes fall through untouched
  always_comb begin
    next_rdata = `DCAP_RDATA_ZERO;
    if (i_cfg_rd && hit_cap) begin
      next_rdata = cap_word;
    end else if (i_cfg_rd && hit_dctl) begin
      next_rdata = dctl_word;
    end
  end

  assign next_ack = i_cfg_rd || i_cfg_wr;

  // Reset ignores the enable so a frozen core still comes up clean
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      load_state <= ST_SETTLE;
    end else if (i_core_ce) begin
      load_state <= next_load_state;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      settle_cnt <= `DCAP_SETTLE_ZERO;
    end else if (i_core_ce) begin
      settle_cnt <= next_settle_cnt;
    end
  end

  // Shows 256 bytes until the strap chain has settled
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      mps_code <= `DCAP_MPS_256;
    end else if (i_core_ce) begin
      mps_code <= next_mps_code;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      role_err <= `DCAP_RBE_RST;
    end else if (i_core_ce) begin
      role_err <= next_role_err;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      spl_value <= `DCAP_SPLV_RST;
    end else if (i_core_ce) begin
      spl_value <= next_spl_value;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      spl_scale <= `DCAP_SPLS_RST;
    end else if (i_core_ce) begin
      spl_scale <= next_spl_scale;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      devctl_mps <= `DCTL_MPS_RST;
    end else if (i_core_ce) begin
      devctl_mps <= next_devctl_mps;
    end
  end

  // Outputs straight from flops
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      o_cfg_ack <= 1'b0;
    end else if (i_core_ce) begin
      o_cfg_ack <= next_ack;
    end
  end

  // Zero when idle so a stale word is never mistaken for a read
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      o_cfg_rdata <= `DCAP_RDATA_ZERO;
    end else if (i_core_ce) begin
      o_cfg_rdata <= next_rdata;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      o_ovr_reject <= 1'b0;
    end else if (i_core_ce) begin
      o_ovr_reject <= next_reject;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      o_strap_loaded <= 1'b0;
    end else if (i_core_ce) begin
      o_strap_loaded <= next_strap_loaded;
    end
  end

  // Mirrors of live state for the datapath
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      o_max_payload_code <= `DCAP_MPS_256;
    end else if (i_core_ce) begin
      o_max_payload_code <= next_mps_code;
    end
  end

  // Follows the next value so the datapath never lags the register
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      o_devctl_payload <= `DCTL_MPS_RST;
    end else if (i_core_ce) begin
      o_devctl_payload <= next_devctl_mps;
    end
  end

endmodule : switch_port_device_capabilities

// File: dv/switch_port_device_capabilities_properties.sv
`timescale 1ns/100ps
`include "dcap_cfg.svh"
module dcap_checker
  import dcap_pkg::*;
#(
  parameter bit UPSTREAM_PORT = 1'b1
) (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_core_ce,
  input wire logic i_cfg_rd,
  input wire logic i_cfg_wr,
  input wire logic [`DCAP_ADDR_W-1:0] i_cfg_addr,
  input wire logic [3:0] i_cfg_be,
  input wire logic [31:0] i_cfg_wdata,
  input wire logic [31:0] o_cfg_rdata,
  input wire logic i_ovr_wr,
  input wire ovr_sel_type i_ovr_sel,
  input wire logic [2:0] i_ovr_data,
  input wire logic o_ovr_reject,
  input wire logic i_spl_msg_valid,
  input wire logic [7:0] i_spl_value,
  input wire logic [1:0] i_spl_scale,
  input wire logic [2:0] o_max_payload_code,
  input wire logic [2:0] o_devctl_payload,
  input wire logic o_strap_loaded
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  wire logic rd = i_core_ce && i_cfg_rd && (i_cfg_addr == `DCAP_OFFSET);
  wire logic pl = i_core_ce && i_ovr_wr && (i_ovr_sel == OVR_PAYLOAD);
  wire logic ro = i_core_ce && i_ovr_wr && (i_ovr_sel == OVR_ROLE_ERR);
  wire logic wc = i_core_ce && i_cfg_wr && i_cfg_be[0] && (i_cfg_addr == `DCTL_OFFSET);
  wire logic rb = i_ovr_data[0];
  wire logic [2:0] cl = (i_cfg_wdata[7:5] > o_max_payload_code) ? o_max_payload_code
    : i_cfg_wdata[7:5];
  wire logic [9:0] spl = UPSTREAM_PORT ? {i_spl_scale, i_spl_value} : 10'h000;
  property p_take; pl && i_ovr_data <= 3'h2 |=> o_max_payload_code == $past(i_ovr_data);
  endproperty
  a_take: assert property (p_take) else $error("override lost");
  property p_reject; pl && i_ovr_data > 3'h2 |=> o_ovr_reject; endproperty
  a_reject: assert property (p_reject) else $error("no reject");
  property p_fixed; rd |=> o_cfg_rdata[11:3] == 9'h000; endproperty
  a_fixed: assert property (p_fixed) else $error("fixed bits");
  property p_rsv; rd |=> {o_cfg_rdata[31:28], o_cfg_rdata[17:16], o_cfg_rdata[14:12]} == 9'h000;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits");
  property p_code; rd && !i_ovr_wr && o_strap_loaded
    |=> o_cfg_rdata[2:0] == $past(o_max_payload_code);
  endproperty
  a_code: assert property (p_code) else $error("payload code");
  property p_role; ro ##1 !i_ovr_wr ##1 rd |=> o_cfg_rdata[15] == $past(rb, 3); endproperty
  a_role: assert property (p_role) else $error("role bit");
  property p_spl; i_core_ce && i_spl_msg_valid ##1 !i_spl_msg_valid ##1 rd
    |=> o_cfg_rdata[27:18] == $past(spl, 3); endproperty
  a_spl: assert property (p_spl) else $error("slot power");
  property p_clamp; wc && !i_ovr_wr |=> o_devctl_payload == $past(cl); endproperty
  a_clamp: assert property (p_clamp) else $error("clamp");
endmodule : dcap_checker
bind switch_port_device_capabilities dcap_checker #(.UPSTREAM_PORT(UPSTREAM_PORT)) i_dcap_checker (
  .i_core_clk, .i_rst_b, .i_core_ce, .i_cfg_rd, .i_cfg_wr, .i_cfg_addr, .i_cfg_be, .i_cfg_wdata,
  .o_cfg_rdata, .i_ovr_wr, .i_ovr_sel, .i_ovr_data, .o_ovr_reject, .i_spl_msg_valid, .i_spl_value,
  .i_spl_scale, .o_max_payload_code, .o_devctl_payload, .o_strap_loaded);

// File: dv/slot_power_sender.sv
`timescale 1ns/100ps
module slot_power_sender (
  input wire logic i_core_clk,
  output logic o_valid,
  output logic [7:0] o_value,
  output logic [1:0] o_scale
);
  initial begin
    o_valid = 1'b0;
    o_value = 8'h00;
    o_scale = 2'h0;
  end
  // Payload inverted after the pulse so a late sample cannot pass
  task automatic send(input logic [7:0] v, input logic [1:0] s);
    @(posedge i_core_clk);
    o_valid <= 1'b1;
    o_value <= v;
    o_scale <= s;
    @(posedge i_core_clk);
    o_valid <= 1'b0;
    o_value <= ~v;
    o_scale <= ~s;
  endtask : send
endmodule : slot_power_sender

// File: dv/tb_switch_port_device_capabilities.sv
`timescale 1ns/100ps
`include "dcap_cfg.svh"
module tb_switch_port_device_capabilities;
  import dcap_pkg::*;
  logic i_core_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_payload_limit_strap = 1'b1;
  logic i_cfg_rd = 1'b0;
  logic i_cfg_wr = 1'b0;
  logic [`DCAP_ADDR_W-1:0] i_cfg_addr = 12'h000;
  logic [31:0] i_cfg_wdata = 32'h0000_0000;
  logic i_core_ce = 1'b1;
  logic [3:0] i_cfg_be = 4'hf;
  logic ack;
  logic [31:0] dn_rdata;
  logic i_ovr_wr = 1'b0;
  ovr_sel_type i_ovr_sel = OVR_PAYLOAD;
  logic [2:0] i_ovr_data = 3'h0;
  logic i_spl_msg_valid, o_cfg_ack, o_ovr_reject, o_strap_loaded;
  logic [7:0] i_spl_value;
  logic [1:0] i_spl_scale;
  logic [31:0] o_cfg_rdata, rdata;
  logic [2:0] o_max_payload_code, o_devctl_payload;
  int num_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  switch_port_device_capabilities i_switch_port_device_capabilities (.i_core_clk, .i_rst_b,
    .i_core_ce, .i_payload_limit_strap, .i_cfg_rd, .i_cfg_wr, .i_cfg_addr,
    .i_cfg_be, .i_cfg_wdata, .o_cfg_ack, .o_cfg_rdata, .i_ovr_wr, .i_ovr_sel, .i_ovr_data,
    .o_ovr_reject, .i_spl_msg_valid, .i_spl_value, .i_spl_scale, .o_max_payload_code,
    .o_devctl_payload, .o_strap_loaded);
  slot_power_sender i_slot_power_sender (.i_core_clk, .o_valid(i_spl_msg_valid),
    .o_value(i_spl_value), .o_scale(i_spl_scale));
  // Downstream copy: slot power fields must never move
  switch_port_device_capabilities #(.UPSTREAM_PORT(1'b0)) i_switch_port_device_capabilities_dn (
    .i_core_clk, .i_rst_b, .i_core_ce, .i_payload_limit_strap, .i_cfg_rd, .i_cfg_wr, .i_cfg_addr,
    .i_cfg_be, .i_cfg_wdata, .o_cfg_ack(), .o_cfg_rdata(dn_rdata), .i_ovr_wr, .i_ovr_sel,
    .i_ovr_data, .o_ovr_reject(), .i_spl_msg_valid, .i_spl_value, .i_spl_scale,
    .o_max_payload_code(), .o_devctl_payload(), .o_strap_loaded());
  always #4 i_core_clk = ~i_core_clk;
  task end_of_test;
    if (num_errors == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  // Bounded run: whole sequence needs about 125 cycles
  always @(posedge i_core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      num_errors++;
      end_of_test;
    end
  end
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task cfg(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    i_cfg_rd <= !w;
    i_cfg_wr <= w;
    i_cfg_addr <= a;
    i_cfg_wdata <= d;
    @(posedge i_core_clk);
    i_cfg_rd <= 1'b0;
    i_cfg_wr <= 1'b0;
    #1 rdata = o_cfg_rdata;
    ack = o_cfg_ack;
  endtask : cfg
  task ovr(input ovr_sel_type s, input logic [2:0] v);
    @(posedge i_core_clk);
    i_ovr_wr <= 1'b1;
    i_ovr_sel <= s;
    i_ovr_data <= v;
    @(posedge i_core_clk);
    i_ovr_wr <= 1'b0;
    #1;
  endtask : ovr
  task t_reset_values;
    for (int s = 1; s >= 0; s--) begin
      @(posedge i_core_clk);
      i_rst_b <= 1'b0;
      i_payload_limit_strap <= s[0];
      repeat (10) @(posedge i_core_clk);
      i_rst_b <= 1'b1;
      repeat (12) @(posedge i_core_clk);
      cfg(1'b0, `DCAP_OFFSET, 32'h0);
      check("cap word", rdata, 32'h0000_8001 + 32'(s));
      check("strap loaded", o_strap_loaded, 1'b1);
      check("payload mirror", o_max_payload_code, 3'h1 + 3'(s));
    end
  endtask : t_reset_values
  task t_read_only;
    cfg(1'b1, `DCAP_OFFSET, 32'hffff_ffff);
    check("write ack", ack, 1'b1);
    check("write rdata", rdata, 32'h0);
    cfg(1'b0, `DCAP_OFFSET, 32'h0);
    check("read ack", ack, 1'b1);
    check("cap after write", rdata, 32'h0000_8001);
  endtask : t_read_only
  task t_override;
    for (int c = 0; c < 8; c++) begin
      ovr(OVR_PAYLOAD, c[2:0]);
      check("reject", o_ovr_reject, c > 2);
      cfg(1'b0, `DCAP_OFFSET, 32'h0);
      check("payload", rdata[2:0], (c > 2) ? 2 : c);
    end
    for (int b = 0; b < 2; b++) begin
      ovr(OVR_ROLE_ERR, 3'(b));
      cfg(1'b0, `DCAP_OFFSET, 32'h0);
      check("role bit", rdata[15], b);
    end
  endtask : t_override
  task t_clamp;
    ovr(OVR_PAYLOAD, 3'h1);
    cfg(1'b1, `DCTL_OFFSET, 32'h0000_00e0);
    check("clamped", o_devctl_payload, 1);
    cfg(1'b1, `DCTL_OFFSET, 32'h0000_0000);
    check("unclamped", o_devctl_payload, 0);
  endtask : t_clamp
  task t_freeze;
    @(posedge i_core_clk);
    i_core_ce <= 1'b0;
    ovr(OVR_PAYLOAD, 3'h0);
    cfg(1'b0, `DCAP_OFFSET, 32'h0);
    check("frozen ack", ack, 1'b0);
    @(posedge i_core_clk);
    i_core_ce <= 1'b1;
    cfg(1'b0, `DCAP_OFFSET, 32'h0);
    check("frozen payload", rdata[2:0], 3'h1);
    @(posedge i_core_clk);
    i_cfg_be <= 4'he;
    cfg(1'b1, `DCTL_OFFSET, 32'h0000_0020);
    check("masked write", o_devctl_payload, 3'h0);
    @(posedge i_core_clk);
    i_cfg_be <= 4'hf;
    cfg(1'b1, `DCTL_OFFSET, 32'h0000_0020);
    check("in range", o_devctl_payload, 3'h1);
    ovr(OVR_PAYLOAD, 3'h0);
    check("reclamp", o_devctl_payload, 3'h0);
  endtask : t_freeze
  task t_slot_power;
    i_slot_power_sender.send(8'h5a, 2'h2);
    cfg(1'b0, `DCAP_OFFSET, 32'h0);
    check("slot power", rdata[27:18], 10'h25a);
    i_slot_power_sender.send(8'ha5, 2'h1);
    cfg(1'b0, `DCAP_OFFSET, 32'h0);
    check("slot power", rdata[27:18], 10'h1a5);
    check("downstream slot power", dn_rdata[27:18], 10'h000);
  endtask : t_slot_power
  initial begin
    t_reset_values;
    t_read_only;
    t_override;
    t_clamp;
    t_freeze;
    t_slot_power;
    end_of_test;
  end
endmodule : tb_switch_port_device_capabilities
